// [core/flash_protect_ctrl.sv]
// SPI front end, protection check, busy, power state and program admission
`timescale 1ns/100ps
module flash_protect_ctrl (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic selectPin_n,
  input wire logic spiClk,
  input wire logic dataIn,
  input wire logic [2:0] rangeBits,
  input wire logic topBottomSel,
  input wire logic sectorGranularity,
  input wire logic complementProtect,
  input wire logic protectSchemeSel,
  input wire logic [7:0] intMask,
  input wire logic [7:0] intClear,
  output logic dataOut,
  output logic busy,
  output logic writeEnableLatch,
  output logic activeMode,
  output logic deepSleep,
  output logic arrayWriteEn,
  output logic [23:0] arrayAddr,
  output logic [7:0] arrayData,
  output logic eraseStart,
  output logic [23:0] eraseMask,
  output logic [7:0] intStatus,
  output logic irq
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] csSync;
    logic [1:0] ckSync;
    logic [1:0] diSync;
    logic ckLast;
    flash_protect_pkg::frame_t frame;
    logic [2:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] opcode;
    logic [1:0] addrCnt;
    logic [23:0] addr;
    logic [8:0] dataCnt;
    logic write_enable_latch;
    logic sleep;
    flash_protect_pkg::cycle_t kind;
    logic [15:0] timer;
    logic [8:0] wrPtr;
    logic wrOn;
    logic [7:0] outByte;
    logic dOut;
    logic actv;
    logic awe;
    logic [23:0] aAddr;
    logic [23:0] eMask;
    logic eStart;
    logic [7:0] status;
    logic irqOut;
  } state_t;
  state_t cur, next_cur;
  logic lockBit, anyLocked, memWr, frameEnd, byteDone, ckRise, ckFall;
  logic [7:0] memRdData, byteVal;
  logic [23:0] unitMask, lo, hi, pLo, pHi;
  logic rangeHit, lockHit, allowed, isWrite;
  logic [flash_protect_pkg::LOCK_W-1:0] lockIdx;
  // ----------------------------------------------------------------
  // Helpers: lock array and page buffer
  // ----------------------------------------------------------------
  lock_bit_array u_locks (
    .core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn),
    .writeEn(frameEnd && byteDone && (cur.opcode == flash_protect_pkg::OP_BLOCK_LOCK ||
      cur.opcode == flash_protect_pkg::OP_BLOCK_UNLOCK) && cur.write_enable_latch && cur.addrCnt == 2'h3),
    .writeIdx(lockIdx),
    .writeVal(cur.opcode == flash_protect_pkg::OP_BLOCK_LOCK),
    .readIdx(lockIdx), .readBit(lockBit), .anyLocked(anyLocked)
  );
  assign memWr = ckRise && cur.frame == flash_protect_pkg::S_DATA && cur.bitCnt == 3'h7;
  flash_page_mem u_page (
    .core_clk(core_clk), .clkEn(clkEn), .writeEn(memWr),
    .writeAddr(8'(cur.addr + 24'(cur.dataCnt))),
    .writeData({cur.shift[6:0], cur.diSync[1]}),
    // Read one cycle ahead so the registered data lines up with the array strobe
    .readAddr(8'(cur.addr[7:0] + cur.wrPtr[7:0] - 8'h1)), .readData(memRdData)
  );
  // ----------------------------------------------------------------
  // Protection check: range window on the whole target unit, lock bit of the start address only, any lock bit for chip erase
  // ----------------------------------------------------------------
  // Lock index: sectors inside the bottom and top blocks, else the 64K block
  always_comb begin
    if (cur.addr[23:16] == 8'h00) begin
      lockIdx = flash_protect_pkg::LOCK_W'(cur.addr[15:12]);
    end else if (cur.addr[23:16] == 8'hFF) begin
      lockIdx = flash_protect_pkg::LOCK_W'(9'h10 + 9'(cur.addr[15:12]));
    end else begin
      lockIdx = flash_protect_pkg::LOCK_W'(9'h1F + 9'(cur.addr[23:16]));
    end
  end
  // Unit size by opcode, then the protected window from the range bits
  always_comb begin
    case (cur.opcode)
      flash_protect_pkg::OP_SECTOR_ERASE: unitMask = flash_protect_pkg::MASK_SECTOR;
      flash_protect_pkg::OP_BLOCK_ERASE32: unitMask = flash_protect_pkg::MASK_BLK32;
      flash_protect_pkg::OP_BLOCK_ERASE64: unitMask = flash_protect_pkg::MASK_BLK64;
      flash_protect_pkg::OP_CHIP_ERASE_A,
      flash_protect_pkg::OP_CHIP_ERASE_B: unitMask = flash_protect_pkg::ADDR_TOP;
      default: unitMask = flash_protect_pkg::MASK_PAGE;
    endcase
    lo = cur.addr & ~unitMask;
    hi = cur.addr | unitMask;
    // Normal window size: 256K << n, or 4K << n sectors (capped at 32K), with n = range bits minus one
    if (sectorGranularity) begin
      pHi = (24'h001000 << (rangeBits[2] ? 3'h3 : 3'(rangeBits[1:0] - 2'h1))) - 24'h1;
    end else begin
      pHi = (24'h040000 << 3'(rangeBits - 3'h1)) - 24'h1;
    end
    pLo = topBottomSel ? 24'h0 : flash_protect_pkg::ADDR_TOP - pHi;
    if (!topBottomSel) begin
      pHi = flash_protect_pkg::ADDR_TOP;
    end
    if (rangeBits == flash_protect_pkg::RANGE_NONE) begin
      rangeHit = complementProtect;
    end else if (rangeBits == flash_protect_pkg::RANGE_ALL) begin
      rangeHit = !complementProtect;
    end else if (!complementProtect) begin
      rangeHit = !(hi < pLo || lo > pHi);
    end else begin
      // Complement protects outside [pLo,pHi]: hit unless unit lies wholly inside
      rangeHit = !(lo >= pLo && hi <= pHi);
    end
    lockHit = (unitMask == flash_protect_pkg::ADDR_TOP) ? anyLocked : lockBit;
    allowed = protectSchemeSel ? !lockHit : !rangeHit;
  end
  // ----------------------------------------------------------------
  // Pin sampling and edges
  // ----------------------------------------------------------------
  assign ckRise = cur.ckSync[1] && !cur.ckLast;
  assign ckFall = !cur.ckSync[1] && cur.ckLast;
  assign frameEnd = cur.csSync[1] && cur.frame != flash_protect_pkg::S_IDLE;
  assign byteDone = cur.bitCnt == 3'h0;
  assign byteVal = {cur.shift[6:0], cur.diSync[1]};
  assign isWrite = cur.opcode == flash_protect_pkg::OP_PAGE_PROGRAM ||
    cur.opcode == flash_protect_pkg::OP_SECTOR_ERASE ||
    cur.opcode == flash_protect_pkg::OP_BLOCK_ERASE32 ||
    cur.opcode == flash_protect_pkg::OP_BLOCK_ERASE64;
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.csSync = {cur.csSync[0], selectPin_n};
    next_cur.ckSync = {cur.ckSync[0], spiClk};
    next_cur.diSync = {cur.diSync[0], dataIn};
    next_cur.ckLast = cur.ckSync[1];
    next_cur.awe = 1'b0;
    next_cur.eStart = 1'b0;
    // Frame decode: an opcode arriving while an internal cycle runs sends the frame to S_IGNORE
    case (cur.frame)
      flash_protect_pkg::S_IDLE: begin
        if (!cur.csSync[1]) begin
          next_cur.frame = flash_protect_pkg::S_OPCODE;
          next_cur.bitCnt = 3'h0;
          next_cur.addrCnt = 2'h0;
          next_cur.dataCnt = 9'h0;
        end
      end
      flash_protect_pkg::S_OPCODE, flash_protect_pkg::S_ADDR,
      flash_protect_pkg::S_DATA, flash_protect_pkg::S_IGNORE: begin
        if (ckRise) begin
          next_cur.shift = byteVal;
          next_cur.bitCnt = cur.bitCnt + 3'h1;
          if (cur.bitCnt == flash_protect_pkg::BIT_MSB) begin
            if (cur.frame == flash_protect_pkg::S_OPCODE) begin
              next_cur.opcode = byteVal;
              // Deep sleep swallows all but the wake opcode
              if ((cur.sleep && byteVal != flash_protect_pkg::OP_WAKE_ID) ||
                  cur.kind != flash_protect_pkg::K_NONE) begin
                next_cur.frame = flash_protect_pkg::S_IGNORE;
              end else if (byteVal == flash_protect_pkg::OP_PAGE_PROGRAM ||
                  byteVal == flash_protect_pkg::OP_SECTOR_ERASE ||
                  byteVal == flash_protect_pkg::OP_BLOCK_ERASE32 ||
                  byteVal == flash_protect_pkg::OP_BLOCK_ERASE64 ||
                  byteVal == flash_protect_pkg::OP_BLOCK_LOCK ||
                  byteVal == flash_protect_pkg::OP_BLOCK_UNLOCK) begin
                next_cur.frame = flash_protect_pkg::S_ADDR;
              end else begin
                next_cur.frame = flash_protect_pkg::S_DATA;
                next_cur.outByte = {6'h0, cur.write_enable_latch, cur.kind != flash_protect_pkg::K_NONE};
              end
            end else if (cur.frame == flash_protect_pkg::S_ADDR) begin
              next_cur.addr = {cur.addr[15:0], byteVal};
              next_cur.addrCnt = cur.addrCnt + 2'h1;
              if (cur.addrCnt == 2'h2) begin
                next_cur.frame = flash_protect_pkg::S_DATA;
              end
            end else if (cur.frame == flash_protect_pkg::S_DATA &&
                cur.dataCnt < 9'(flash_protect_pkg::PAGE_BYTES)) begin
              next_cur.dataCnt = cur.dataCnt + 9'h1;
            end
          end
        end
        if (ckFall) begin
          next_cur.dOut = cur.outByte[flash_protect_pkg::BIT_MSB];
          next_cur.outByte = {cur.outByte[6:0], cur.outByte[7]};
        end
        // Select rising: commit only on a byte boundary
        if (frameEnd) begin
          next_cur.frame = flash_protect_pkg::S_IDLE;
          next_cur.dOut = 1'b0;
          if (byteDone && cur.frame != flash_protect_pkg::S_IGNORE) begin
            case (cur.opcode)
              flash_protect_pkg::OP_WRITE_ENABLE: next_cur.write_enable_latch = 1'b1;
              flash_protect_pkg::OP_WRITE_DISABLE: next_cur.write_enable_latch = 1'b0;
              flash_protect_pkg::OP_DEEP_SLEEP: next_cur.sleep = 1'b1;
              flash_protect_pkg::OP_WAKE_ID: next_cur.sleep = 1'b0;
              flash_protect_pkg::OP_STATUS_WRITE: begin
                if (cur.write_enable_latch && cur.dataCnt != 9'h0) begin
                  next_cur.kind = flash_protect_pkg::K_STATUS;
                  next_cur.timer = flash_protect_pkg::CYC_STATUS;
                end
              end
              flash_protect_pkg::OP_CHIP_ERASE_A, flash_protect_pkg::OP_CHIP_ERASE_B: begin
                if (cur.write_enable_latch && allowed) begin
                  next_cur.kind = flash_protect_pkg::K_ERASE;
                  next_cur.timer = flash_protect_pkg::CYC_ERASE;
                  next_cur.eStart = 1'b1;
                  next_cur.eMask = flash_protect_pkg::ADDR_TOP;
                  next_cur.aAddr = 24'h0;
                end
              end
              default: begin
                // Only a complete program or erase with a latched enable runs
                if (isWrite && cur.write_enable_latch && allowed && cur.addrCnt == 2'h3) begin
                  if (cur.opcode == flash_protect_pkg::OP_PAGE_PROGRAM) begin
                    if (cur.dataCnt != 9'h0) begin
                      next_cur.kind = flash_protect_pkg::K_PROG;
                      next_cur.timer = flash_protect_pkg::CYC_PROG;
                      next_cur.wrPtr = 9'h0;
                      next_cur.wrOn = 1'b1;
                    end
                  end else begin
                    next_cur.kind = flash_protect_pkg::K_ERASE;
                    next_cur.timer = flash_protect_pkg::CYC_ERASE;
                    next_cur.eStart = 1'b1;
                    next_cur.eMask = unitMask;
                    next_cur.aAddr = lo;
                  end
                end
              end
            endcase
          end
        end
      end
      default: next_cur.frame = flash_protect_pkg::S_IDLE;
    endcase
    // Program streams buffered bytes; array side ANDs so only 1->0 happens
    if (cur.wrOn) begin
      next_cur.wrPtr = cur.wrPtr + 9'h1;
      if (cur.wrPtr != 9'h0) begin
        next_cur.awe = 1'b1;
        next_cur.aAddr = {cur.addr[23:8], 8'(cur.addr[7:0] + cur.wrPtr[7:0] - 8'h1)};
        next_cur.eMask = 24'h0;
      end
      if (cur.wrPtr == cur.dataCnt) begin
        next_cur.wrOn = 1'b0;
      end
    end
    // Internal cycle timer, busy and latch auto-clear
    if (cur.kind != flash_protect_pkg::K_NONE) begin
      next_cur.timer = cur.timer - 16'h1;
      if (cur.timer == 16'h1) begin
        next_cur.kind = flash_protect_pkg::K_NONE;
        next_cur.write_enable_latch = 1'b0;
        next_cur.status[cur.kind] = 1'b1;
      end
    end
    // Sticky events; set wins over a write-one clear
    next_cur.status = next_cur.status & ~intClear;
    if (cur.kind != flash_protect_pkg::K_NONE && cur.timer == 16'h1) begin
      next_cur.status[cur.kind] = 1'b1;
    end
    next_cur.irqOut = |(next_cur.status & intMask);
    // Active while selected or an internal cycle runs
    next_cur.actv = !cur.csSync[1] || next_cur.kind != flash_protect_pkg::K_NONE;
  end
  // ----------------------------------------------------------------
  // Register stage
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cur <= '0;
      cur.csSync <= 2'h3;
    end else if (clkEn) begin
      cur <= next_cur;
    end
  end
  assign dataOut = cur.dOut;
  assign busy = cur.kind != flash_protect_pkg::K_NONE;
  assign writeEnableLatch = cur.write_enable_latch;
  assign activeMode = cur.actv;
  assign deepSleep = cur.sleep;
  assign arrayWriteEn = cur.awe;
  assign arrayAddr = cur.aAddr;
  assign arrayData = memRdData;
  assign eraseStart = cur.eStart;
  assign eraseMask = cur.eMask;
  assign intStatus = cur.status;
  assign irq = cur.irqOut;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_wel_clears: assert property (@(posedge core_clk) disable iff (!reset_n)
    clkEn && busy && cur.timer == 16'h1 |=> !writeEnableLatch)
    else $error("latch not cleared at cycle end");
  a_erase_needs_wel: assert property (@(posedge core_clk) disable iff (!reset_n)
    eraseStart |-> $past(cur.write_enable_latch))
    else $error("erase without enable latch");
  a_sleep_no_erase: assert property (@(posedge core_clk) disable iff (!reset_n)
    eraseStart |-> !$past(cur.sleep))
    else $error("erase started in deep sleep");
  a_busy_on_erase: assert property (@(posedge core_clk) disable iff (!reset_n)
    eraseStart |-> busy)
    else $error("erase without busy");
  a_active_busy: assert property (@(posedge core_clk) disable iff (!reset_n)
    busy |-> activeMode)
    else $error("standby while busy");
  a_erase_allowed: assert property (@(posedge core_clk) disable iff (!reset_n)
    eraseStart |-> $past(allowed))
    else $error("protected erase started");
  a_prog_unit: assert property (@(posedge core_clk) disable iff (!reset_n)
    arrayWriteEn |-> arrayAddr[23:8] == cur.addr[23:8])
    else $error("program left its page");
  a_irq_level: assert property (@(posedge core_clk) disable iff (!reset_n)
    clkEn |=> irq == |(intStatus & $past(intMask)) || !clkEn)
    else $error("irq mismatch");
  c_erase: cover property (@(posedge core_clk) eraseStart);
  c_prog: cover property (@(posedge core_clk) arrayWriteEn);
  c_sleep: cover property (@(posedge core_clk) $rose(deepSleep));
endmodule // flash_protect_ctrl

// [core/flash_protect_pkg.sv]
// Constants, encodings and types for the flash write-protect and program admission block
// Functional notes
// - Complement set protects exactly what the same range bits leave unprotected.
// - Program or erase touching any protected byte is ignored, nothing changes; lock bits check only the start sector of a bottom or top block erase.
// - Lock bits count only while the scheme selector is one.
// - At power-up every lock bit is one, whole array locked.
// - Page program is opcode, three address bytes, then data bytes.
// - At most 256 data bytes per program, wrapping inside one page.
// - Programming only clears bits; a zero never returns to one.
// - Erase sets every byte of sector, block or array to FFh.
// - Busy bit high through status write, program or erase cycles; here only on the busy output, as status reads while busy are ignored.
// - Active while selected or busy, otherwise standby.
// - Deep sleep entered by its opcode, left only by wake opcode.
// - In deep sleep every other instruction is ignored.
// - Scheme selector zero uses range bits, one uses per-block locks.
// - Lock bit one blocks program or erase of that unit.
// - Write enable latch clears when program, erase or status write ends.
// - Write-type instructions count only if select rises on a byte boundary.
package flash_protect_pkg;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK_ERASE32 = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE64 = 8'hD8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'h60;
  localparam logic [7:0] OP_BLOCK_LOCK = 8'h36;
  localparam logic [7:0] OP_BLOCK_UNLOCK = 8'h39;
  localparam logic [7:0] OP_DEEP_SLEEP = 8'hB9;
  localparam logic [7:0] OP_WAKE_ID = 8'hAB;
  // ----------------------------------------------------------------
  // Geometry and fields
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam int LOCK_N = 286;
  localparam int LOCK_W = 9;
  localparam int PAGE_BYTES = 256;
  localparam logic [23:0] ADDR_TOP = 24'hFFFFFF;
  localparam logic [23:0] MASK_PAGE = 24'h0000FF;
  localparam logic [23:0] MASK_SECTOR = 24'h000FFF;
  localparam logic [23:0] MASK_BLK32 = 24'h007FFF;
  localparam logic [23:0] MASK_BLK64 = 24'h00FFFF;
  localparam logic [2:0] RANGE_NONE = 3'h0;
  localparam logic [2:0] RANGE_ALL = 3'h7;
  localparam logic [2:0] BIT_MSB = 3'h7;
  localparam logic [7:0] BYTE_ERASED = 8'hFF;
  // Status bit positions of the busy/latch byte
  localparam int ST_BUSY = 0;
  localparam int ST_WEL = 1;
  // ----------------------------------------------------------------
  // Internal cycle timing (ns) and derived cycle counts at 100 MHz
  // ----------------------------------------------------------------
  localparam int CLK_NS = 10;
  localparam int T_STATUS_NS = 200;
  localparam int T_PROG_NS = 400;
  localparam int T_ERASE_NS = 800;
  localparam logic [15:0] CYC_STATUS = 16'((T_STATUS_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] CYC_PROG = 16'((T_PROG_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [15:0] CYC_ERASE = 16'((T_ERASE_NS + CLK_NS - 1) / CLK_NS);
  // ----------------------------------------------------------------
  // Frame decoder states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_OPCODE = 3'b001,
    S_ADDR = 3'b010,
    S_DATA = 3'b011,
    S_IGNORE = 3'b100
  } frame_t;
  typedef enum logic [1:0] {
    K_NONE = 2'b00,
    K_STATUS = 2'b01,
    K_PROG = 2'b10,
    K_ERASE = 2'b11
  } cycle_t;
endpackage

// [core/lock_bit_array.sv]
// Per-block and per-sector lock bits with registered lookup
`timescale 1ns/100ps
module lock_bit_array (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clkEn,
  input wire logic writeEn,
  input wire logic [flash_protect_pkg::LOCK_W-1:0] writeIdx,
  input wire logic writeVal,
  input wire logic [flash_protect_pkg::LOCK_W-1:0] readIdx,
  output logic readBit,
  output logic anyLocked
);
  logic [flash_protect_pkg::LOCK_N-1:0] locks;
  // One flop per lock bit; reset sets all of them so the array starts locked
  genvar g;
  generate
    for (g = 0; g < flash_protect_pkg::LOCK_N; g++) begin : g_lock
      always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
          locks[g] <= 1'b1;
        end else if (clkEn && writeEn && writeIdx == flash_protect_pkg::LOCK_W'(g)) begin
          locks[g] <= writeVal;
        end
      end
    end
  endgenerate
  // Registered read port
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      readBit <= 1'b1;
      anyLocked <= 1'b1;
    end else if (clkEn) begin
      readBit <= (readIdx < flash_protect_pkg::LOCK_W'(flash_protect_pkg::LOCK_N))
        ? locks[readIdx] : 1'b1;
      anyLocked <= |locks;
    end
  end
endmodule // lock_bit_array

// [core/flash_page_mem.sv]
// Small page-buffer memory holding program data, registered read
`timescale 1ns/100ps
module flash_page_mem (
  input wire logic core_clk,
  input wire logic clkEn,
  input wire logic writeEn,
  input wire logic [7:0] writeAddr,
  input wire logic [7:0] writeData,
  input wire logic [7:0] readAddr,
  output logic [7:0] readData
);
  logic [7:0] mem [0:flash_protect_pkg::PAGE_BYTES-1];
  // Plain buffer write; the array side ANDs, so bits only ever clear
  always_ff @(posedge core_clk) begin
    if (clkEn) begin
      if (writeEn) begin
        mem[writeAddr] <= writeData;
      end
      readData <= mem[readAddr];
    end
  end
endmodule // flash_page_mem

// [verif/spi_host_model.sv]
// Serial host model that frames instructions toward the flash block
`timescale 1ns/100ps
module spi_host_model (
  input wire logic core_clk,
  output logic selectPin_n,
  output logic spiClk,
  output logic dataIn
);
  initial begin
    selectPin_n = 1'b1;
    spiClk = 1'b0;
    dataIn = 1'b0;
  end
  // ----------------------------------------------------------------
  // Frame task: 160 ns link clock, standing low outside frames
  // ----------------------------------------------------------------
  // Data idles on the inverse of its last bit so a stale value never looks valid
  task automatic send(input logic [63:0] f, input int n);
    selectPin_n <= 1'b0;
    for (int i = 0; i < n; i++) begin
      dataIn <= f[63-i]; // MSB first, n bits from the caller, which may end mid-byte
      repeat (8) @(posedge core_clk);
      spiClk <= 1'b1;
      repeat (8) @(posedge core_clk);
      spiClk <= 1'b0;
    end
    repeat (8) @(posedge core_clk);
    selectPin_n <= 1'b1;
    dataIn <= ~dataIn;
  endtask
endmodule // spi_host_model

// [verif/tb.sv]
// Self-checking bench for the flash protect and program admission block
`timescale 1ns/100ps
module tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic clkEn = 1'b1;
  logic [2:0] rangeBits = 3'h0;
  logic topBottomSel = 1'b0, sectorGranularity = 1'b0, complementProtect = 1'b1;
  logic protectSchemeSel = 1'b1;
  logic [7:0] intMask = 8'hFF, intClear = 8'h00, arrayData, intStatus, lastData;
  logic selectPin_n, spiClk, dataIn, dataOut, busy, writeEnableLatch, activeMode, deepSleep;
  logic arrayWriteEn, eraseStart, irq, irqA;
  logic [23:0] arrayAddr, eraseMask, lastMask, lastAddr;
  int fails = 0, samples_checked = 0, cycles = 0, nErase = 0, nWrite = 0, busySeen = 0;
  flash_protect_ctrl flash_protect_ctrl_inst (.core_clk, .reset_n, .clkEn, .selectPin_n,
    .spiClk, .dataIn, .rangeBits, .topBottomSel, .sectorGranularity, .complementProtect,
    .protectSchemeSel, .intMask, .intClear, .dataOut, .busy, .writeEnableLatch, .activeMode,
    .deepSleep, .arrayWriteEn, .arrayAddr, .arrayData, .eraseStart, .eraseMask, .intStatus,
    .irq);
  spi_host_model spi_host_model_inst (.core_clk, .selectPin_n, .spiClk, .dataIn);
  always #5 core_clk = ~core_clk;
  // Pulse monitor and hang guard; the ceiling is well above the planned run
  always @(posedge core_clk) begin
    cycles++;
    if (busy === 1'b1) busySeen = 1;
    if (eraseStart === 1'b1) begin
      nErase++;
      lastMask = eraseMask;
      lastAddr = arrayAddr;
    end
    if (arrayWriteEn === 1'b1) begin
      nWrite++;
      lastAddr = arrayAddr;
      lastData = arrayData;
    end
    if (cycles == 60000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("FAIL %s expected %h seen %h", s, e, g);
    end
  endtask
  // One instruction, optionally after write enable; waits out busy under a bound
  task automatic run(input logic [63:0] f, input int n, input bit we);
    int k;
    k = 0;
    if (we) spi_host_model_inst.send({flash_protect_pkg::OP_WRITE_ENABLE, 56'h0}, 8);
    repeat (8) @(posedge core_clk);
    nErase = 0;
    nWrite = 0;
    busySeen = 0;
    spi_host_model_inst.send(f, n);
    repeat (10) @(posedge core_clk);
    while (busy !== 1'b0 && k < 400) begin
      @(posedge core_clk);
      k++;
    end
    repeat (4) @(posedge core_clk);
  endtask
  task automatic er(input logic [7:0] op, input logic [23:0] a, input int exp);
    run({op, a, 32'h0}, (op == flash_protect_pkg::OP_CHIP_ERASE_A) ? 8 : 32, 1'b1);
    chk("eraseCount", exp, nErase);
  endtask
  task automatic t_locks;
    rangeBits <= 3'h7;
    er(flash_protect_pkg::OP_SECTOR_ERASE, 24'h000000, 0);
    protectSchemeSel <= 1'b0;
    er(flash_protect_pkg::OP_SECTOR_ERASE, 24'h000123, 1);
    chk("eraseMask", flash_protect_pkg::MASK_SECTOR, lastMask);
    chk("eraseBase", 24'h000000, lastAddr);
    chk("busySeen", 1, busySeen);
    chk("latch", 0, writeEnableLatch);
    chk("active", 0, activeMode);
  endtask
  task automatic t_range;
    rangeBits <= 3'h0;
    er(flash_protect_pkg::OP_BLOCK_ERASE64, 24'h100000, 0);
    rangeBits <= 3'h1;
    er(flash_protect_pkg::OP_SECTOR_ERASE, 24'hFC0000, 1);
    er(flash_protect_pkg::OP_SECTOR_ERASE, 24'hFBF000, 0);
    er(flash_protect_pkg::OP_BLOCK_ERASE64, 24'hFB0000, 0);
    er(flash_protect_pkg::OP_CHIP_ERASE_A, 24'h0, 0);
    rangeBits <= 3'h7;
    er(flash_protect_pkg::OP_CHIP_ERASE_A, 24'h0, 1);
  endtask
  task automatic t_prog;
    run({flash_protect_pkg::OP_PAGE_PROGRAM, 24'h001234, 8'hA5, 24'h0}, 40, 1'b0);
    chk("progNoLatch", 0, nWrite);
    run({flash_protect_pkg::OP_PAGE_PROGRAM, 24'h001234, 8'hA5, 24'h0}, 39, 1'b1);
    chk("progRagged", 0, nWrite);
    run({flash_protect_pkg::OP_PAGE_PROGRAM, 24'h0012FF, 16'hA53C, 16'h0}, 48, 1'b1);
    chk("progCount", 2, nWrite);
    chk("progWrap", 24'h001200, lastAddr);
    chk("progData", 8'h3C, lastData);
  endtask
  task automatic t_sleep;
    spi_host_model_inst.send({flash_protect_pkg::OP_DEEP_SLEEP, 56'h0}, 8);
    repeat (10) @(posedge core_clk);
    chk("sleep", 1, deepSleep);
    er(flash_protect_pkg::OP_SECTOR_ERASE, 24'hFC0000, 0);
    spi_host_model_inst.send({flash_protect_pkg::OP_WAKE_ID, 56'h0}, 8);
    repeat (10) @(posedge core_clk);
    chk("wake", 0, deepSleep);
  endtask
  // Mask polarity is left open, so only the difference between two masks is judged
  task automatic t_irq;
    chk("eraseDone", 1, intStatus[3]);
    irqA = irq;
    intMask <= 8'h00;
    repeat (3) @(posedge core_clk);
    chk("irqMask", 1, irqA ^ irq);
    clkEn <= 1'b0;
    intClear <= 8'hFF;
    repeat (3) @(posedge core_clk);
    chk("frozen", 1, intStatus[3]);
    clkEn <= 1'b1;
    @(posedge core_clk);
    intClear <= 8'h00;
    repeat (3) @(posedge core_clk);
    chk("cleared", 0, {intStatus, irq});
  endtask
  task automatic give_verdict;
    if (fails == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    t_locks();
    t_range();
    t_prog();
    t_sleep();
    t_irq();
    give_verdict();
  end
endmodule // tb
